// [design/btse_pkg.sv]
package btse_pkg;
  // APB register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_INSTR = 12'h004;
  localparam logic [11:0] ADDR_OPADDR = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [5:0] RF_WINDOW = 6'h01;
  localparam logic [15:0] EXT_STEP = 16'h0002;
  localparam logic [15:0] PTR_STEP = 16'h0002;
  // Control register bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_BUSY = 0;
  localparam int CTRL_ILLEGAL = 1;
  // Status word layout, low byte only
  localparam int STAT_Z = 4;
  localparam int STAT_N = 5;
  localparam int STAT_C = 6;
  localparam int STAT_V = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Primary opcodes
  localparam logic [7:0] OP_BTS_LIT_REG = 8'h96;
  localparam logic [7:0] OP_BTS_SRC_REG = 8'hE6;
  localparam logic [7:0] OP_BTS_LIT_MEM = 8'h97;
  localparam logic [7:0] OP_BTS_SRC_MEM = 8'hE7;
  localparam logic [7:0] OP_EA_STORE = 8'hF1;
  localparam logic [7:0] OP_STATUS_SAVE = 8'hA9;
  localparam logic [6:0] OP_SUB_RR = 7'h1C;
  localparam logic [6:0] OP_SUB_RM = 7'h1D;
  localparam logic [6:0] OP_SUB_IR = 7'h1E;
  localparam logic [6:0] OP_SUB_MR = 7'h1F;
  localparam logic [6:0] OP_QUICK_REG = 7'h43;
  localparam logic [6:0] OP_QUICK_MEM = 7'h44;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_EXEC = 5'b00010,
    S_FETCH = 5'b00100,
    S_READ = 5'b01000,
    S_WRITE = 5'b10000
  } btse_state_e;
  typedef struct packed {
    logic req;
    logic we;
    logic size_byte;
    logic lock;
    logic [15:0] addr;
    logic [15:0] wdata;
  } btse_mem_s;
  // Difference with flags at byte or word width: {v,c,n,z,result}
  function automatic logic [19:0] btse_sub(input logic [15:0] d, input logic [15:0] s,
                                           input logic is_byte);
    logic [16:0] w;
    logic z;
    logic n;
    logic c;
    logic v;
    w = is_byte ? ({9'h000, d[7:0]} - {9'h000, s[7:0]}) : ({1'b0, d} - {1'b0, s});
    if (is_byte)
    begin
      z = (w[7:0] == 8'h00);
      n = w[7];
      c = w[8];
      v = (d[7] ^ s[7]) & (d[7] ^ w[7]);
    end
    else
    begin
      z = (w[15:0] == 16'h0000);
      n = w[15];
      c = w[16];
      v = (d[15] ^ s[15]) & (d[15] ^ w[15]);
    end
    return {v, c, n, z, w[15:0]};
  endfunction : btse_sub
endpackage : btse_pkg

// [design/btse_exec.sv]
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Test-and-store loads Z with inverted selected bit, then writes carry into it.
// - Byte form bits 0-7 memory only; word 0-15 register; 8-15 rewrites unmodified.
// - Test-and-store sets Z when bit was 0; N, C, V unchanged.
// - Effective address store writes displacement plus source at destination pointer.
// - Destination pointer then advances by two.
// - Status save copies whole status word to destination before modifying it.
// - Then the three low quick literal bits load the interrupt level.
// - Status save clears Z, N, C and V.
// - Status upper byte is reserved; reads as zero, keeps nothing written.
// - Subtract destination minus source into destination; register, immediate, memory forms.
// - Subtract flags: Z on zero, N top bit, C on unsigned underflow (borrow), V on signed overflow.
// - Byte subtract zero-extends; upper result byte is 00 or FF with carry.
// - Byte memory destination gets low byte; register gets whole word.
// - Flags evaluated at bit 7 for byte, bit 15 for word.
// - Quick subtract uses zero-extended 4-bit literal on register or memory.
// - Quick subtract into register takes one cycle; immediate subtract takes at least three (fetch, ack, execute).
module btse_exec
  import btse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output btse_mem_s mem_o,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy
);
  btse_state_e state_q, state_d;
  btse_mem_s mem_q, mem_d;
  logic [15:0] rf_q [16];
  logic [15:0] rf_d [16];
  logic [15:0] instr_q, instr_d, opaddr_q, opaddr_d, ext_q, ext_d;
  logic [15:0] opnd_q, opnd_d, addr_q, addr_d;
  logic [7:0] stat_q, stat_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, busy_q, busy_d, illegal_q, illegal_d;

  // Register read with the zero register hard-wired
  function automatic logic [15:0] rf_rd(input logic [3:0] i, input logic [15:0] v);
    return (i == 4'h0) ? 16'h0000 : v;
  endfunction : rf_rd

  // Decode from the primary opcode byte
  logic [7:0] op;
  logic [3:0] rd_i, src_i, lit;
  logic is_bts, bts_mem, bts_lit, is_ea_store, is_save;
  logic sub_rr, sub_rm, sub_ir, sub_mr, quick_r, quick_m, is_sub, is_byte;
  logic need_ext, need_read, mem_dst, legal;
  logic [15:0] rd_v, src_v, dval, sval;
  logic [3:0] bsel;
  logic [19:0] calc;
  logic tst_bit;
  always_comb
  begin
    op = instr_q[15:8];
    rd_i = instr_q[3:0];
    src_i = instr_q[7:4];
    lit = instr_q[7:4];
    rd_v = rf_rd(rd_i, rf_q[rd_i]);
    src_v = rf_rd(src_i, rf_q[src_i]);
    bts_lit = (op == OP_BTS_LIT_REG) || (op == OP_BTS_LIT_MEM);
    bts_mem = (op == OP_BTS_LIT_MEM) || (op == OP_BTS_SRC_MEM);
    is_bts = bts_lit || (op == OP_BTS_SRC_REG) || (op == OP_BTS_SRC_MEM);
    is_ea_store = (op == OP_EA_STORE);
    is_save = (op == OP_STATUS_SAVE);
    sub_rr = (op[7:1] == OP_SUB_RR);
    sub_rm = (op[7:1] == OP_SUB_RM);
    sub_ir = (op[7:1] == OP_SUB_IR);
    sub_mr = (op[7:1] == OP_SUB_MR);
    quick_r = (op[7:1] == OP_QUICK_REG);
    quick_m = (op[7:1] == OP_QUICK_MEM);
    is_sub = sub_rr || sub_rm || sub_ir || sub_mr || quick_r || quick_m;
    is_byte = is_sub & op[0];
    mem_dst = bts_mem || sub_rm || quick_m;
    need_read = mem_dst || sub_mr;
    need_ext = need_read || is_ea_store || sub_ir;
    legal = is_bts || is_ea_store || is_save || is_sub;
    bsel = bts_lit ? lit : src_v[3:0];
    dval = mem_dst ? opnd_q : rd_v;
    // Memory-destination form still takes its source from a register
    if (sub_rr || sub_rm)
      sval = src_v;
    else if (sub_ir)
      sval = ext_q;
    else if (sub_mr)
      sval = opnd_q;
    else
      sval = {12'h000, lit};
    calc = btse_sub(dval, sval, is_byte);
    tst_bit = dval[bsel];
  end

  // Sequencer, datapath and APB slave next state
  logic acc, mapped, rfwin;
  always_comb
  begin
    state_d = state_q;
    mem_d = mem_q;
    rf_d = rf_q;
    instr_d = instr_q;
    opaddr_d = opaddr_q;
    ext_d = ext_q;
    opnd_d = opnd_q;
    addr_d = addr_q;
    stat_d = stat_q;
    illegal_d = illegal_q;
    rfwin = (paddr[11:6] == RF_WINDOW) && (paddr[1:0] == 2'b00);
    mapped = rfwin || (paddr == ADDR_CTRL) || (paddr == ADDR_INSTR)
             || (paddr == ADDR_OPADDR) || (paddr == ADDR_STATUS);
    acc = psel && penable && pready_q;
    // One wait state; data and error are ready with pready
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = 32'h0000_0000;
    if (rfwin)
      prdata_d = {16'h0000, rf_rd(paddr[5:2], rf_q[paddr[5:2]])};
    else if (paddr == ADDR_CTRL)
      prdata_d = {30'h0, illegal_q, busy_q};
    else if (paddr == ADDR_INSTR)
      prdata_d = {16'h0000, instr_q};
    else if (paddr == ADDR_OPADDR)
      prdata_d = {16'h0000, opaddr_q};
    else if (paddr == ADDR_STATUS)
      prdata_d = {24'h000000, stat_q};
    // Software writes are ignored while an operation runs
    if (acc && pwrite && mapped && (state_q == S_IDLE))
    begin
      if (rfwin && (paddr[5:2] != 4'h0))
        rf_d[paddr[5:2]] = pwdata[15:0];
      if (paddr == ADDR_INSTR)
        instr_d = pwdata[15:0];
      if (paddr == ADDR_OPADDR)
        opaddr_d = pwdata[15:0];
      if (paddr == ADDR_STATUS)
        stat_d = pwdata[7:0];
      if ((paddr == ADDR_CTRL) && pwdata[CTRL_GO])
      begin
        illegal_d = !legal;
        if (legal && need_ext)
        begin
          state_d = S_FETCH;
          mem_d = '{req: 1'b1, we: 1'b0, size_byte: 1'b0, lock: 1'b0,
                    addr: opaddr_q + EXT_STEP, wdata: 16'h0000};
        end
        else if (legal)
          state_d = S_EXEC;
      end
    end
    unique case (state_q)
      S_IDLE:
      begin
      end
      S_FETCH:
        if (mem_ack)
        begin
          ext_d = mem_rdata;
          addr_d = mem_rdata + (sub_mr ? src_v : rd_v);
          mem_d.req = 1'b0;
          if (is_ea_store)
          begin
            state_d = S_WRITE;
            mem_d = '{req: 1'b1, we: 1'b1, size_byte: 1'b0, lock: 1'b0,
                      addr: rd_v, wdata: mem_rdata + src_v};
          end
          else if (need_read)
          begin
            state_d = S_READ;
            mem_d = '{req: 1'b1, we: 1'b0, size_byte: is_byte | bts_mem,
                      lock: bts_mem, addr: mem_rdata + (sub_mr ? src_v : rd_v),
                      wdata: 16'h0000};
          end
          else
            state_d = S_EXEC;
        end
      S_READ:
        if (mem_ack)
        begin
          opnd_d = (is_byte | bts_mem) ? {8'h00, mem_rdata[7:0]} : mem_rdata;
          mem_d.req = 1'b0; // Lock stays up for the write that follows
          state_d = S_EXEC;
        end
      S_EXEC:
      begin
        state_d = S_IDLE;
        if (is_bts)
        begin
          // Bits 8-15 on a byte target leave the byte as read
          if (!(bts_mem && bsel[3]))
          begin
            stat_d[STAT_Z] = !tst_bit;
            if (bts_mem)
              opnd_d[bsel[2:0]] = stat_q[STAT_C];
            else if (rd_i != 4'h0)
              rf_d[rd_i][bsel] = stat_q[STAT_C];
          end
          if (bts_mem)
          begin
            state_d = S_WRITE;
            mem_d = '{req: 1'b1, we: 1'b1, size_byte: 1'b1, lock: 1'b1, addr: addr_q,
                      wdata: bsel[3] ? opnd_q :
                             (opnd_q & ~(16'h0001 << bsel[2:0]))
                             | ({15'h0000, stat_q[STAT_C]} << bsel[2:0])};
          end
        end
        else if (is_save)
        begin
          if (rd_i != 4'h0)
            rf_d[rd_i] = {8'h00, stat_q};
          stat_d = {4'h0, stat_q[3], lit[2:0]};
        end
        else if (is_sub)
        begin
          stat_d[STAT_Z] = calc[16];
          stat_d[STAT_N] = calc[17];
          stat_d[STAT_C] = calc[18];
          stat_d[STAT_V] = calc[19];
          if (mem_dst)
          begin
            state_d = S_WRITE;
            mem_d = '{req: 1'b1, we: 1'b1, size_byte: is_byte, lock: 1'b0, addr: addr_q,
                      wdata: is_byte ? {8'h00, calc[7:0]} : calc[15:0]};
          end
          else if (rd_i != 4'h0)
            rf_d[rd_i] = calc[15:0];
        end
      end
      S_WRITE:
        if (mem_ack)
        begin
          mem_d.req = 1'b0;
          mem_d.we = 1'b0;
          mem_d.lock = 1'b0;
          if (is_ea_store && (rd_i != 4'h0))
            rf_d[rd_i] = rd_v + PTR_STEP;
          state_d = S_IDLE;
        end
    endcase
    busy_d = (state_d != S_IDLE);
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      mem_q <= '0;
      for (int i = 0; i < 16; i++)
        rf_q[i] <= 16'h0000;
      instr_q <= 16'h0000;
      opaddr_q <= 16'h0000;
      ext_q <= 16'h0000;
      opnd_q <= 16'h0000;
      addr_q <= 16'h0000;
      stat_q <= STAT_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      busy_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mem_q <= mem_d;
      rf_q <= rf_d;
      instr_q <= instr_d;
      opaddr_q <= opaddr_d;
      ext_q <= ext_d;
      opnd_q <= opnd_d;
      addr_q <= addr_d;
      stat_q <= stat_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      busy_q <= busy_d;
      illegal_q <= illegal_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_o = mem_q;
  assign busy = busy_q;

  // Checks on the datapath
  AST_BTS_Z: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && is_bts && !bts_mem) |=> stat_q[STAT_Z] == !$past(tst_bit))
    else $error("test-and-store Z wrong");
  AST_BTS_NCV: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && is_bts) |=> $stable(stat_q[7:5]))
    else $error("test-and-store touched N C V");
  AST_BYTE_HIGH_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && bts_mem && bsel[3]) |=> mem_q.wdata == $past(opnd_q))
    else $error("high bit number modified byte");
  AST_EA_INC: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_WRITE && mem_ack && is_ea_store && rd_i != 4'h0)
    |=> rf_q[rd_i] == $past(rf_q[rd_i]) + PTR_STEP)
    else $error("pointer not advanced by two");
  AST_EA_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_q && is_ea_store) |=> $stable(stat_q))
    else $error("address store changed flags");
  AST_SAVE_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && is_save) |=> stat_q[2:0] == $past(instr_q[6:4]))
    else $error("level field not loaded");
  AST_SAVE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && is_save) |=> stat_q[7:4] == 4'h0)
    else $error("flags not cleared");
  AST_BYTE_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && is_sub && is_byte && !mem_dst && rd_i != 4'h0)
    |=> rf_q[rd_i][15:8] == {8{stat_q[STAT_C]}})
    else $error("byte result upper byte wrong");
  AST_QUICK_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_EXEC && quick_r) |=> state_q == S_IDLE)
    else $error("quick subtract not single cycle");
  AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == S_READ && bts_mem) |=> mem_q.lock [*2])
    else $error("semaphore lock dropped");
endmodule : btse_exec
`default_nettype wire

// [tb/btse_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Program and data memory on the CPU bus
module btse_mem_model
  import btse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire btse_mem_s mem_o,
  input wire logic [3:0] lat,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  // Whole 64K-word space; the bench preloads every word that gets read
  logic [15:0] m [65536];
  logic [3:0] cnt;
  // Ack after lat stall cycles; idle data toggles so stale data never matches
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end
    else if (mem_ack || !mem_o.req)
    begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (cnt != lat)
    begin
      cnt <= cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
    else
    begin
      mem_ack <= 1'b1;
      // Byte writes touch the low lane only
      if (mem_o.we && mem_o.size_byte)
        m[mem_o.addr][7:0] = mem_o.wdata[7:0];
      else if (mem_o.we)
        m[mem_o.addr] = mem_o.wdata;
      if (mem_o.size_byte)
        mem_rdata <= {~mem_rdata[15:8], m[mem_o.addr][7:0]};
      else
        mem_rdata <= m[mem_o.addr];
    end
  end
endmodule : btse_mem_model
`default_nettype wire

// [tb/test_bit_test_store_subtract_exec.sv]
`timescale 1ns/1ps
`default_nettype none
module test_bit_test_store_subtract_exec
  import btse_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  btse_mem_s mem_o;
  logic [15:0] mem_rdata;
  logic mem_ack;
  logic busy;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int total_checks = 0;
  int cyc;

  btse_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  btse_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_o(mem_o), .lat(lat),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // 50 MHz clock
  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; pready !== 1'b1; n++)
    begin
      if (n == 50)
      begin
        miscompares++;
        close_out();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdr

  function automatic logic [11:0] ra(input logic [3:0] n);
    return 12'h040 + {6'h00, n, 2'b00};
  endfunction : ra

  // Start an operation and count the cycles busy stays high
  task automatic run(input logic [15:0] ins);
    wr(ADDR_INSTR, {16'h0000, ins});
    wr(ADDR_CTRL, 32'h1);
    cyc = 0;
    @(posedge pclk);
    while (busy === 1'b1)
    begin
      if (cyc == 300)
      begin
        miscompares++;
        close_out();
      end
      cyc++;
      @(posedge pclk);
    end
  endtask : run

  // Register-destination difference, R1 source, R2 destination
  task automatic sc(input logic [7:0] op, input logic [3:0] nb, input logic [15:0] d, s, x,
                    res, input logic [7:0] st);
    wr(ra(1), {16'h0, s});
    wr(ra(2), {16'h0, d});
    mem.m[16'h0102] = x;
    run({op, nb, 4'h2});
    rdr(ra(2));
    chk("sub result", res, rd[15:0]);
    rdr(ra(1));
    chk("sub source", s, rd[15:0]);
    rdr(ADDR_STATUS);
    chk("sub flags", {8'h00, st}, rd[15:0]);
  endtask : sc

  // Memory destination at displacement a off the zero register
  task automatic mq(input logic [7:0] op, input logic [3:0] nb, input logic [15:0] a, v, res,
                    input logic [7:0] st);
    mem.m[16'h0102] = a;
    mem.m[a] = v;
    run({op, nb, 4'h0});
    chk("memory result", res, mem.m[a]);
    rdr(ADDR_STATUS);
    chk("memory flags", {8'h00, st}, rd[15:0]);
  endtask : mq

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdr(ADDR_STATUS);
    chk("status reset", 16'h0000, rd[15:0]);
    rdr(12'h100);
    chk("unmapped error", 16'h0001, {15'h0, err});
    wr(ADDR_OPADDR, 32'h100);
    wr(ra(0), 32'h55);
    rdr(ra(0));
    chk("zero register", 16'h0000, rd[15:0]);
    // Differences: underflow, overflow, zero, byte width
    sc(8'h38, 4'h1, 16'h0005, 16'h0007, 16'h0, 16'hFFFE, 8'h60);
    sc(8'h39, 4'h1, 16'h1205, 16'h3407, 16'h0, 16'hFFFE, 8'h60);
    sc(8'h38, 4'h1, 16'h8000, 16'h0001, 16'h0, 16'h7FFF, 8'h80);
    sc(8'h39, 4'h1, 16'h0080, 16'h0001, 16'h0, 16'h007F, 8'h80);
    sc(8'h39, 4'h1, 16'hAB10, 16'h0010, 16'h0, 16'h0000, 8'h10);
    sc(8'h86, 4'hF, 16'h000F, 16'h1111, 16'h0, 16'h0000, 8'h10);
    chk("quick cycles", 16'h0001, cyc[15:0]);
    sc(8'h87, 4'h3, 16'h0001, 16'h1111, 16'h0, 16'hFFFE, 8'h60);
    sc(8'h3C, 4'h1, 16'h0010, 16'h0001, 16'h0003, 16'h000D, 8'h00);
    chk("immediate cycles", 16'h0001, {15'h0, cyc > 1});
    // Memory destinations with a stalling bus
    lat <= 4'h2;
    mq(8'h88, 4'h7, 16'h0300, 16'h0005, 16'hFFFE, 8'h60);
    mq(8'h89, 4'h1, 16'h0302, 16'h1234, 16'h1233, 8'h00);
    wr(ra(1), 32'h3);
    mq(8'h3A, 4'h1, 16'h0304, 16'h0010, 16'h000D, 8'h00);
    // Semaphore bit, register forms
    wr(ADDR_STATUS, 32'h40);
    wr(ra(3), 32'h4);
    run({8'h96, 4'h5, 4'h3});
    rdr(ra(3));
    chk("bit word", 16'h0024, rd[15:0]);
    rdr(ADDR_STATUS);
    chk("bit flags", 16'h0050, rd[15:0]);
    wr(ADDR_STATUS, 32'h20);
    wr(ra(1), 32'h12);
    run({8'hE6, 4'h1, 4'h3});
    rdr(ra(3));
    chk("bit by register", 16'h0020, rd[15:0]);
    rdr(ADDR_STATUS);
    chk("bit flags", 16'h0020, rd[15:0]);
    // Semaphore bit in memory, then out-of-range byte bit number
    wr(ADDR_STATUS, 32'h40);
    mq(8'h97, 4'h3, 16'h0200, 16'hAB00, 16'hAB08, 8'h50);
    mq(8'h97, 4'h9, 16'h0204, 16'h00FF, 16'h00FF, 8'h50);
    // Effective address store through post-stepped pointer
    wr(ADDR_STATUS, 32'hF5);
    wr(ra(1), 32'h2);
    wr(ra(4), 32'h8000);
    mem.m[16'h0102] = 16'h6000;
    run({8'hF1, 4'h1, 4'h4});
    chk("address stored", 16'h6002, mem.m[16'h8000]);
    rdr(ra(4));
    chk("pointer step", 16'h8002, rd[15:0]);
    rdr(ADDR_STATUS);
    chk("address flags", 16'h00F5, rd[15:0]);
    // Status save and level load
    wr(ADDR_STATUS, 32'hFFF8);
    rdr(ADDR_STATUS);
    chk("status upper", 16'h00F8, rd[15:0]);
    run({8'hA9, 4'hD, 4'h5});
    rdr(ra(5));
    chk("saved status", 16'h00F8, rd[15:0]);
    rdr(ADDR_STATUS);
    chk("level load", 16'h000D, rd[15:0]);
    run(16'h0000);
    rdr(ADDR_CTRL);
    chk("illegal flag", 16'h0002, rd[15:0]);
    close_out();
  end
endmodule : test_bit_test_store_subtract_exec
`default_nettype wire
